// [inc/fcg_defines.vh]
// Constants for the flash command gate and emulated-EEPROM command block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef FCG_DEFINES_VH
`define FCG_DEFINES_VH

// Command array geometry.
`define FCG_DATA_W        16
`define FCG_IDX_W         3
`define FCG_DEPTH         8

// Command array indices.
`define FCG_IDX_CODE      3'h0
`define FCG_IDX_DATAFLASH_PARTITION_SIZE    3'h1
`define FCG_IDX_EMUL_BUFFER_PARTITION_SIZE    3'h2
`define FCG_IDX_SECTOR_ERASE_COUNT    3'h3
`define FCG_IDX_SECTORS   3'h4

// Command code field of index 000.
`define FCG_CODE_MSB      15
`define FCG_CODE_LSB      8

// Command codes.
`define FCG_CMD_ERS_VFY_ALL 8'h01
`define FCG_CMD_ERS_VFY_BLK 8'h02
`define FCG_CMD_ERS_VFY_SEC 8'h03
`define FCG_CMD_LOAD_FIELD  8'h05
`define FCG_CMD_PGM_ONCE    8'h07
`define FCG_CMD_ERS_ALL     8'h08
`define FCG_CMD_ERS_PBLK    8'h09
`define FCG_CMD_ERS_PSEC    8'h0a
`define FCG_CMD_UNSECURE    8'h0b
`define FCG_CMD_BACKDOOR    8'h0c
`define FCG_CMD_USER_MARGIN 8'h0d
`define FCG_CMD_FIELD_MRG   8'h0e
`define FCG_CMD_FULL_PART   8'h0f
`define FCG_CMD_ERS_VFY_DF  8'h10
`define FCG_CMD_ERS_DSEC    8'h12
`define FCG_CMD_EMUL_ON     8'h13
`define FCG_CMD_EMUL_OFF    8'h14
`define FCG_CMD_EMUL_QUERY  8'h15
`define FCG_CMD_PARTITION   8'h20

// Values returned by a query before any partitioning.
`define FCG_UNPART_SIZE   16'hffff
`define FCG_UNPART_SECT   16'h0000

// Reset values and the erase count ceiling.
`define FCG_RST_INDEX     3'h0
`define FCG_RST_SECTOR_ERASE_COUNT    16'h0000
`define FCG_SECTOR_ERASE_COUNT_MAX    16'hffff

`endif

// [src/fcg_cmd_array.v]
// Eight-entry command array storage for the flash command gate.
// Assumes one clock; read data are registered and appear one edge after the address.
`include "fcg_defines.vh"

module fcg_cmd_array (
  // Clock and reset
  input  wire                     clk_i,
  input  wire                     reset_n_i,
  // Write port
  input  wire                     wr_en_i,
  input  wire [`FCG_IDX_W-1:0]    wr_idx_i,
  input  wire [`FCG_DATA_W-1:0]   wr_data_i,
  // Read port
  input  wire [`FCG_IDX_W-1:0]    rd_idx_i,
  output reg  [`FCG_DATA_W-1:0]   rd_data_o
);

  reg [`FCG_DATA_W-1:0] mem [0:`FCG_DEPTH-1];

  // Array contents are left uninitialised, like the rest of the command RAM.
  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= mem[rd_idx_i];
    end
  end

endmodule

// [src/fcg_top.v]
// Flash command gate: mode-dependent command acceptance plus the
// disable-emulation and emulation-query commands.
// Assumes all inputs synchronous to clk_i; a flash engine outside runs every
// other accepted command except enable-emulation and answers with exec_done_i.
`include "fcg_defines.vh"

// Contract
// - Codes 01,02,13,14,15,20 are accepted in all eight modes.
// - Codes 08 and 0B accepted only in the special modes, secured or not.
// - Code 0C accepted only in normal single-chip mode, secured or not.
// - Codes 0E and 0F accepted only in unsecured special modes.
// - Codes 03-07,09,0A,0D,10-12 need unsecured, or secured normal single-chip.
// - Disable-emulation halts emulation at a safe point, keeps tags, then completes.
// - Disable-emulation with index not 000 sets access error; other flags untouched.
// - Disable-emulation sets access error while a load-data-field sequence is active.
// - Disable-emulation sets access error if no partition command ran before.
// - Query writes partition sizes, erase count and sector counts to indices 1-4.
// - Returned erase count is the number of sector erases performed.
// - Query sets completion only after all returned values are stored.
// - Unpartitioned query returns all-ones sizes and count, zero sector counts.
module fcg_top (
  // Clock and reset
  input  wire                     clk_i,
  input  wire                     reset_n_i,
  // Operating mode
  input  wire                     secured_i,
  input  wire                     special_mode_i,
  input  wire                     single_chip_i,
  // Command array access by software
  input  wire                     index_wr_i,
  input  wire [`FCG_IDX_W-1:0]    index_wdata_i,
  input  wire                     array_wr_i,
  input  wire [`FCG_DATA_W-1:0]   array_wdata_i,
  output wire [`FCG_DATA_W-1:0]   command_array_o,
  output reg  [`FCG_IDX_W-1:0]    command_array_index_o,
  // Launch and status
  input  wire                     launch_i,
  input  wire                     access_error_clr_i,
  output reg                      command_complete_flag_o,
  output reg                      access_error_flag_o,
  // Flash engine for accepted commands other than codes 13, 14 and 15
  output reg                      exec_req_o,
  output reg  [7:0]               exec_code_o,
  input  wire                     exec_done_i,
  input  wire                     load_field_active_i,
  input  wire                     sector_erased_i,
  // Emulated-EEPROM state
  output reg                      emul_active_o,
  output reg                      emul_halt_req_o,
  input  wire                     emul_idle_i,
  output reg                      partitioned_o,
  input  wire [`FCG_DATA_W-1:0]   dataflash_partition_size_i,
  input  wire [`FCG_DATA_W-1:0]   emul_buffer_partition_size_i,
  input  wire [7:0]               dead_sector_count_i,
  input  wire [7:0]               ready_sector_count_i
);

  ////////////////////////////////////////////////////////////////////////////
  // States

  localparam [2:0] S_IDLE  = 3'b000;
  localparam [2:0] S_FETCH = 3'b001;
  localparam [2:0] S_CHECK = 3'b010;
  localparam [2:0] S_EXEC  = 3'b011;
  localparam [2:0] S_HALT  = 3'b100;
  localparam [2:0] S_QUERY = 3'b101;

  reg  [2:0]              state;
  reg  [2:0]              next_state;
  reg  [`FCG_IDX_W-1:0]   launch_index;
  reg  [`FCG_IDX_W-1:0]   query_idx;
  reg  [`FCG_DATA_W-1:0]  sector_erase_count;
  reg  [7:0]              exec_code;

  wire                    normal_single_chip;
  wire                    special_mode;
  wire [7:0]              command_code;
  wire                    code_allowed;
  reg                     seq_wr;
  reg  [`FCG_DATA_W-1:0]  seq_wdata;
  wire                    mem_wr;
  wire [`FCG_IDX_W-1:0]   mem_wr_idx;
  wire [`FCG_DATA_W-1:0]  mem_wdata;
  wire [`FCG_IDX_W-1:0]   mem_rd_idx;
  reg                     set_access_error;

  ////////////////////////////////////////////////////////////////////////////
  // Command acceptance per mode

  assign normal_single_chip = single_chip_i & ~special_mode_i;
  assign special_mode       = special_mode_i;

  function allowed;
    input [7:0] code;
    input       sec;
    input       spec;
    input       nsc;
    begin
      case (code)
        `FCG_CMD_ERS_VFY_ALL, `FCG_CMD_ERS_VFY_BLK,
        `FCG_CMD_EMUL_ON, `FCG_CMD_EMUL_OFF,
        `FCG_CMD_EMUL_QUERY, `FCG_CMD_PARTITION: begin
          allowed = 1'b1;
        end
        `FCG_CMD_ERS_ALL, `FCG_CMD_UNSECURE: begin
          allowed = spec;
        end
        `FCG_CMD_BACKDOOR: begin
          allowed = nsc;
        end
        `FCG_CMD_FIELD_MRG, `FCG_CMD_FULL_PART: begin
          allowed = spec & ~sec;
        end
        default: begin
          if (((code >= `FCG_CMD_ERS_VFY_SEC) && (code <= `FCG_CMD_PGM_ONCE)) ||
              (code == `FCG_CMD_ERS_PBLK) || (code == `FCG_CMD_ERS_PSEC) ||
              (code == `FCG_CMD_USER_MARGIN) ||
              ((code >= `FCG_CMD_ERS_VFY_DF) && (code <= `FCG_CMD_ERS_DSEC))) begin
            allowed = ~sec | nsc;
          end else begin
            allowed = 1'b0;
          end
        end
      endcase
    end
  endfunction

  assign command_code = command_array_o[`FCG_CODE_MSB:`FCG_CODE_LSB];
  assign code_allowed = allowed(command_code, secured_i, special_mode,
                                normal_single_chip);

  ////////////////////////////////////////////////////////////////////////////
  // Command array storage

  // Software may only write the array while no command runs, so the
  // sequencer's result writes never collide with a software write.
  assign mem_wr     = seq_wr | (array_wr_i & command_complete_flag_o);
  assign mem_wr_idx = seq_wr ? query_idx : command_array_index_o;
  assign mem_wdata  = seq_wr ? seq_wdata : array_wdata_i;
  // Both fetch edges read entry 000, so the check sees the code whatever the index.
  assign mem_rd_idx = ((next_state == S_FETCH) || (next_state == S_CHECK)) ? `FCG_IDX_CODE :
                      (index_wr_i ? index_wdata_i : command_array_index_o);

  fcg_cmd_array u_array (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (mem_wr),
    .wr_idx_i  (mem_wr_idx),
    .wr_data_i (mem_wdata),
    .rd_idx_i  (mem_rd_idx),
    .rd_data_o (command_array_o)
  );

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      command_array_index_o <= `FCG_RST_INDEX;
    end else if (index_wr_i) begin
      command_array_index_o <= index_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Query result selection

  always @* begin
    seq_wr    = (state == S_QUERY);
    seq_wdata = `FCG_UNPART_SECT;
    case (query_idx)
      `FCG_IDX_DATAFLASH_PARTITION_SIZE: begin
        seq_wdata = partitioned_o ? dataflash_partition_size_i
                                  : `FCG_UNPART_SIZE;
      end
      `FCG_IDX_EMUL_BUFFER_PARTITION_SIZE: begin
        seq_wdata = partitioned_o ? emul_buffer_partition_size_i
                                  : `FCG_UNPART_SIZE;
      end
      `FCG_IDX_SECTOR_ERASE_COUNT: begin
        seq_wdata = partitioned_o ? sector_erase_count
                                  : `FCG_UNPART_SIZE;
      end
      default: begin
        seq_wdata = partitioned_o ? {dead_sector_count_i, ready_sector_count_i}
                                  : `FCG_UNPART_SECT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always @* begin
    next_state       = state;
    set_access_error = 1'b0;
    case (state)
      S_IDLE: begin
        if (launch_i && command_complete_flag_o) begin
          next_state = S_FETCH;
        end
      end
      S_FETCH: begin
        next_state = S_CHECK;
      end
      S_CHECK: begin
        next_state = S_IDLE;
        if (!code_allowed) begin
          set_access_error = 1'b1;
        end else if (command_code == `FCG_CMD_EMUL_OFF) begin
          // Only the access error flag is touched; the other flags belong
          // to the engine and stay as they are.
          if ((launch_index != `FCG_IDX_CODE) ||
              load_field_active_i ||
              !partitioned_o) begin
            set_access_error = 1'b1;
          end else begin
            next_state = S_HALT;
          end
        end else if (command_code == `FCG_CMD_EMUL_QUERY) begin
          next_state = S_QUERY;
        end else if (command_code != `FCG_CMD_EMUL_ON) begin
          next_state = S_EXEC;
        end
      end
      S_EXEC: begin
        if (exec_done_i) begin
          next_state = S_IDLE;
        end
      end
      S_HALT: begin
        if (emul_idle_i) begin
          next_state = S_IDLE;
        end
      end
      S_QUERY: begin
        if (query_idx == `FCG_IDX_SECTORS) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state                   <= S_IDLE;
      launch_index            <= `FCG_RST_INDEX;
      query_idx               <= `FCG_IDX_DATAFLASH_PARTITION_SIZE;
      command_complete_flag_o <= 1'b1;
      exec_req_o              <= 1'b0;
      exec_code_o             <= 8'h00;
      exec_code               <= 8'h00;
      emul_active_o           <= 1'b0;
      emul_halt_req_o         <= 1'b0;
      partitioned_o           <= 1'b0;
    end else begin
      state      <= next_state;
      exec_req_o <= 1'b0;
      if (state == S_IDLE && next_state == S_FETCH) begin
        command_complete_flag_o <= 1'b0;
        launch_index            <= command_array_index_o;
        query_idx               <= `FCG_IDX_DATAFLASH_PARTITION_SIZE;
      end
      if (state == S_CHECK) begin
        exec_code <= command_code;
        if (next_state == S_IDLE) begin
          command_complete_flag_o <= 1'b1;
          if (code_allowed && command_code == `FCG_CMD_EMUL_ON &&
              !set_access_error) begin
            emul_active_o <= 1'b1;
          end
        end
        if (next_state == S_EXEC) begin
          exec_req_o  <= 1'b1;
          exec_code_o <= command_code;
        end
        if (next_state == S_HALT) begin
          emul_halt_req_o <= 1'b1;
        end
      end
      if (state == S_EXEC && exec_done_i) begin
        command_complete_flag_o <= 1'b1;
        if (exec_code == `FCG_CMD_PARTITION || exec_code == `FCG_CMD_FULL_PART) begin
          partitioned_o <= 1'b1;
        end
      end
      // Tag memory and tag counter live outside and are never cleared here.
      if (state == S_HALT && emul_idle_i) begin
        emul_halt_req_o         <= 1'b0;
        emul_active_o           <= 1'b0;
        command_complete_flag_o <= 1'b1;
      end
      if (state == S_QUERY) begin
        query_idx <= query_idx + 3'h1;
        if (query_idx == `FCG_IDX_SECTORS) begin
          command_complete_flag_o <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access error flag and erase counter

  // A new error in the clearing cycle wins, so it is never lost.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      access_error_flag_o <= 1'b0;
    end else if (set_access_error) begin
      access_error_flag_o <= 1'b1;
    end else if (access_error_clr_i) begin
      access_error_flag_o <= 1'b0;
    end
  end

  // Saturates rather than wraps, so a worn device never reports a low count.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sector_erase_count <= `FCG_RST_SECTOR_ERASE_COUNT;
    end else if (sector_erased_i && sector_erase_count != `FCG_SECTOR_ERASE_COUNT_MAX) begin
      sector_erase_count <= sector_erase_count + 16'h0001;
    end
  end

endmodule

// [sim/fcg_top_asserts.sv]
// Checker for fcg_top: command gating by mode and the emulation commands.
// Assumes mode inputs and load_field_active_i stay steady while a command runs.
`include "fcg_defines.vh"

module fcg_top_asserts (
  // Watched ports
  input logic                   clk_i,
  input logic                   reset_n_i,
  input logic                   secured_i,
  input logic                   special_mode_i,
  input logic                   single_chip_i,
  input logic                   array_wr_i,
  input logic [`FCG_DATA_W-1:0] array_wdata_i,
  input logic [`FCG_IDX_W-1:0]  command_array_index_o,
  input logic                   launch_i,
  input logic                   access_error_clr_i,
  input logic                   command_complete_flag_o,
  input logic                   access_error_flag_o,
  input logic                   exec_req_o,
  input logic [7:0]             exec_code_o,
  input logic                   load_field_active_i,
  input logic                   emul_active_o,
  input logic                   emul_halt_req_o,
  input logic                   emul_idle_i,
  input logic                   partitioned_o
);
  reg  [7:0] code;
  wire       go  = launch_i && command_complete_flag_o;
  wire       nsc = single_chip_i && !special_mode_i;
  wire       spc = code == 8'h13 || code == 8'h14 || code == 8'h15;
  wire       off = go && code == 8'h14;
  wire       done_err = command_complete_flag_o && access_error_flag_o;

  // The code is tracked at the write port, since the array itself is hidden.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) code <= 8'h00;
    else if (array_wr_i && command_complete_flag_o && command_array_index_o == 3'h0)
      code <= array_wdata_i[15:8];
  end

  function automatic logic ok(input logic [7:0] c);
    case (c)
      8'h01, 8'h02, 8'h13, 8'h14, 8'h15, 8'h20: ok = 1'b1;
      8'h08, 8'h0b: ok = special_mode_i;
      8'h0c: ok = nsc;
      8'h0e, 8'h0f: ok = special_mode_i && !secured_i;
      8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0d, 8'h10, 8'h11, 8'h12:
        ok = !secured_i || nsc;
      default: ok = 1'b0;
    endcase
  endfunction

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  ////////////////////////////////////////////////////////////////////////////////
  property p_reject; go && !ok(code) |-> ##[3:5] done_err; endproperty
  a_reject: assert property (p_reject)
    else $error("refused code did not end with access error");
  property p_exec;
    go && ok(code) && !spc |-> ##[2:5] (exec_req_o && exec_code_o == code) ##1 !exec_req_o;
  endproperty
  a_exec: assert property (p_exec)
    else $error("accepted code not handed to the engine");
  property p_query;
    go && code == 8'h15 |-> ##2 (!command_complete_flag_o)[*5] ##[1:4] command_complete_flag_o;
  endproperty
  a_query: assert property (p_query)
    else $error("query completed too early or too late");
  property p_emul_on; go && code == 8'h13 |-> ##[3:5] (command_complete_flag_o && emul_active_o);
  endproperty
  a_emul_on: assert property (p_emul_on)
    else $error("enable emulation did not complete");
  property p_dis_idx; off && command_array_index_o != 3'h0 |-> ##[3:5] done_err; endproperty
  a_dis_idx: assert property (p_dis_idx)
    else $error("disable with bad index gave no access error");
  property p_dis_load; off && load_field_active_i |-> ##[3:5] done_err; endproperty
  a_dis_load: assert property (p_dis_load)
    else $error("disable during load field gave no access error");
  property p_dis_part; off && !partitioned_o |-> ##[3:5] done_err; endproperty
  a_dis_part: assert property (p_dis_part)
    else $error("disable before partition gave no access error");
  property p_dis_halt;
    off && command_array_index_o == 3'h0 && !load_field_active_i && partitioned_o
      |-> ##[2:5] emul_halt_req_o;
  endproperty
  a_dis_halt: assert property (p_dis_halt)
    else $error("disable did not request a halt");
  property p_halt_wait; emul_halt_req_o && !emul_idle_i |=> !command_complete_flag_o; endproperty
  a_halt_wait: assert property (p_halt_wait)
    else $error("disable completed before emulation was idle");
  property p_err_hold; access_error_flag_o && !access_error_clr_i |=> access_error_flag_o;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("access error dropped without a clear");
  // A clean completion of either partition command must leave the block partitioned.
  property p_part;
    $rose(command_complete_flag_o) && !access_error_flag_o && (code == 8'h20 || code == 8'h0f)
      |-> partitioned_o;
  endproperty
  a_part: assert property (p_part)
    else $error("partition completed without marking the block partitioned");

  c_query: cover property (go && code == 8'h15);
  c_reject: cover property (go && !ok(code));
  c_halt: cover property (emul_halt_req_o && emul_idle_i);
endmodule

bind fcg_top fcg_top_asserts u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .secured_i(secured_i),
  .special_mode_i(special_mode_i), .single_chip_i(single_chip_i), .array_wr_i(array_wr_i),
  .array_wdata_i(array_wdata_i), .command_array_index_o(command_array_index_o),
  .launch_i(launch_i), .access_error_clr_i(access_error_clr_i),
  .command_complete_flag_o(command_complete_flag_o), .access_error_flag_o(access_error_flag_o),
  .exec_req_o(exec_req_o), .exec_code_o(exec_code_o), .load_field_active_i(load_field_active_i),
  .emul_active_o(emul_active_o), .emul_halt_req_o(emul_halt_req_o), .emul_idle_i(emul_idle_i),
  .partitioned_o(partitioned_o));

// [sim/fcg_top_test.sv]
// Self-checking bench for fcg_top: emulation query, disable and a mode sweep.
// Assumes the bench stands in for software and for the flash engine.
`include "fcg_defines.vh"

module fcg_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0, reset_n_i = 1'b0, secured_i = 1'b0, special_mode_i = 1'b0;
  logic        single_chip_i = 1'b1, index_wr_i = 1'b0, array_wr_i = 1'b0, launch_i = 1'b0;
  logic        access_error_clr_i = 1'b0, exec_done_i = 1'b0, load_field_active_i = 1'b0;
  logic        sector_erased_i = 1'b0, emul_idle_i = 1'b0, rd_tick = 1'b0, last_cc = 1'b1;
  logic [2:0]  index_wdata_i = 3'h0, command_array_index_o;
  logic [15:0] array_wdata_i = 16'h0000, dfp = 16'h0000, erp = 16'h0000, command_array_o;
  logic [7:0]  dead = 8'h00, ready = 8'h00, exec_code_o;
  logic        command_complete_flag_o, access_error_flag_o, exec_req_o;
  logic        emul_active_o, emul_halt_req_o, partitioned_o;
  logic        err_q[$];
  logic [15:0] dat_q[$];
  logic [7:0]  codes[24] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
    8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
    8'h20, 8'h16, 8'hff};
  int          fails = 0, checks_done = 0, m, n;

  always #4 clk_i = ~clk_i;

  fcg_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .secured_i(secured_i),
    .special_mode_i(special_mode_i), .single_chip_i(single_chip_i), .index_wr_i(index_wr_i),
    .index_wdata_i(index_wdata_i), .array_wr_i(array_wr_i), .array_wdata_i(array_wdata_i),
    .command_array_o(command_array_o), .command_array_index_o(command_array_index_o),
    .launch_i(launch_i), .access_error_clr_i(access_error_clr_i),
    .command_complete_flag_o(command_complete_flag_o), .access_error_flag_o(access_error_flag_o),
    .exec_req_o(exec_req_o), .exec_code_o(exec_code_o), .exec_done_i(exec_done_i),
    .load_field_active_i(load_field_active_i), .sector_erased_i(sector_erased_i),
    .emul_active_o(emul_active_o), .emul_halt_req_o(emul_halt_req_o), .emul_idle_i(emul_idle_i),
    .partitioned_o(partitioned_o), .dataflash_partition_size_i(dfp),
    .emul_buffer_partition_size_i(erp), .dead_sector_count_i(dead), .ready_sector_count_i(ready));

  ////////////////////////////////////////////////////////////////////////////////
  // Engine stand-in answers each request and each halt one cycle later.
  always @(posedge clk_i) begin
    exec_done_i <= exec_req_o;
    emul_idle_i <= emul_halt_req_o;
  end

  always @(posedge clk_i) begin
    last_cc <= command_complete_flag_o;
    if (reset_n_i && command_complete_flag_o && !last_cc)
      cmp_err(err_q.size() ? err_q.pop_front() : 1'bx, access_error_flag_o);
    if (rd_tick)
      cmp_dat(dat_q.size() ? dat_q.pop_front() : 16'hxxxx, command_array_o);
  end

  task automatic cmp_err(input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED access_error_flag_o expected %b seen %b", e, g);
    end
  endtask

  task automatic cmp_dat(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED command_array_o expected %h seen %h", e, g);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic allowed(input logic [7:0] c, input logic s, input logic sp,
                                   input logic ns);
    case (c)
      8'h01, 8'h02, 8'h13, 8'h14, 8'h15, 8'h20: allowed = 1'b1;
      8'h08, 8'h0b: allowed = sp;
      8'h0c: allowed = ns;
      8'h0e, 8'h0f: allowed = sp & ~s;
      8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0d, 8'h10, 8'h11, 8'h12:
        allowed = ~s | ns;
      default: allowed = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic set_idx(input logic [2:0] i);
    index_wr_i    <= 1'b1;
    index_wdata_i <= i;
    @(posedge clk_i);
    index_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [2:0] i, input logic [15:0] e);
    set_idx(i);
    dat_q.push_back(e);
    rd_tick <= 1'b1;
    @(posedge clk_i);
    rd_tick <= 1'b0;
  endtask

  // Launches one command and waits, bounded, for the completion flag.
  task automatic run(input logic [7:0] code, input logic [2:0] li, input logic err);
    int k;
    set_idx(3'h0);
    array_wr_i    <= 1'b1;
    array_wdata_i <= {code, 8'h00};
    @(posedge clk_i);
    array_wr_i <= 1'b0;
    set_idx(li);
    access_error_clr_i <= 1'b1;
    @(posedge clk_i);
    access_error_clr_i <= 1'b0;
    err_q.push_back(err);
    launch_i <= 1'b1;
    @(posedge clk_i);
    launch_i <= 1'b0;
    @(posedge clk_i);
    for (k = 0; k < 64; k++) begin
      @(posedge clk_i);
      if (command_complete_flag_o === 1'b1) break;
    end
    if (k == 64) begin
      fails++;
      end_of_test();
    end
  endtask

  initial begin
    void'($urandom(21));
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    dfp       <= 16'($urandom);
    erp       <= 16'($urandom);
    dead      <= 8'($urandom);
    ready     <= 8'($urandom);
    n = $urandom_range(6, 1);
    @(posedge clk_i);
    run(`FCG_CMD_EMUL_QUERY, 3'h0, 1'b0);
    rd(`FCG_IDX_DATAFLASH_PARTITION_SIZE, `FCG_UNPART_SIZE);
    rd(`FCG_IDX_EMUL_BUFFER_PARTITION_SIZE, `FCG_UNPART_SIZE);
    rd(`FCG_IDX_SECTOR_ERASE_COUNT, `FCG_UNPART_SIZE);
    rd(`FCG_IDX_SECTORS, `FCG_UNPART_SECT);
    run(`FCG_CMD_EMUL_OFF, 3'h0, 1'b1);
    run(`FCG_CMD_PARTITION, 3'h0, 1'b0);
    repeat (n) begin
      sector_erased_i <= 1'b1;
      @(posedge clk_i);
      sector_erased_i <= 1'b0;
      @(posedge clk_i);
    end
    run(`FCG_CMD_EMUL_QUERY, 3'h0, 1'b0);
    rd(`FCG_IDX_DATAFLASH_PARTITION_SIZE, dfp);
    rd(`FCG_IDX_EMUL_BUFFER_PARTITION_SIZE, erp);
    rd(`FCG_IDX_SECTOR_ERASE_COUNT, 16'(n));
    rd(`FCG_IDX_SECTORS, {dead, ready});
    $display("test query done");
    run(`FCG_CMD_EMUL_OFF, 3'($urandom_range(7, 1)), 1'b1);
    load_field_active_i <= 1'b1;
    run(`FCG_CMD_EMUL_OFF, 3'h0, 1'b1);
    load_field_active_i <= 1'b0;
    run(`FCG_CMD_EMUL_ON, 3'h0, 1'b0);
    run(`FCG_CMD_EMUL_OFF, 3'h0, 1'b0);
    $display("test disable done");
    for (m = 0; m < 8; m++) begin
      {secured_i, special_mode_i, single_chip_i} <= 3'(m);
      @(posedge clk_i);
      foreach (codes[j])
        run(codes[j], 3'h0, !allowed(codes[j], m[2], m[1], m[0] & ~m[1]));
    end
    $display("test modes done");
    end_of_test();
  end
endmodule
